// ---- verilog/sacs_sequencer.sv ----
// successive-approximation sequencer for a 10-bit converter
// assumes the cpu gives one-cycle instruction pulses on core_clk, the
// conversion clock tick and comparator output come from other domains
// How it works
// - start instruction begins a conversion
// - clear result register before comparing
// - first step sets top bit, compares
// - keep bit if reference below input
// - repeat down through the lowest bit
// - done after start overhead plus trials
// - done flag and interrupt condition together
// - ten-bit result, read as eight plus two
// - interrupt taken or skip clears flag
`timescale 1ns/1ps
module sacs_sequencer import sacs_pkg::*; #(
   parameter int PREP_CLKS = START_CLKS
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // cpu instruction strobes
   input wire logic conversion_start_instr,
   input wire logic done_flag_skip_instr,
   input wire logic irq_taken,
   // conversion clock from the divider, asynchronous
   input wire logic conversion_clock,
   // comparator: high when reference is below analog_input_voltage
   input wire logic cmp_ref_below,
   // to the d/a ladder and cpu
   output logic [9:0] dac_code,
   output sacs_result_t result,
   output logic conversion_done_flag,
   output logic adc_irq_req,
   output logic busy
);
   // sequencer state and counters
   sacs_state_t st_q, st_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] cnt_q, cnt_d;

   // result register, one flop per bit
   logic [9:0] res_q, res_d;

   // completion flag and its interrupt pulse
   logic flag_q, flag_d;
   logic irq_d;

   // first stage only feeds the second, third keeps the last level
   logic [2:0] ck_sync_q, ck_sync_d;
   logic [1:0] cmp_sync_q, cmp_sync_d;

   // strobes from the control group to the per-bit logic
   logic tick;
   logic cmp_seen;
   logic do_clear;
   logic do_msb;
   logic do_decide;
   logic last_bit;
   logic [3:0] next_bit;

   // next values of the registered outputs
   logic [9:0] dac_code_d;
   sacs_result_t result_d;
   logic busy_d;

   // synchronisers for the two inputs from other domains
   always_comb begin
      ck_sync_d = {ck_sync_q[1:0], conversion_clock};
      cmp_sync_d = {cmp_sync_q[0], cmp_ref_below};
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ck_sync_q <= 3'h0;
         cmp_sync_q <= 2'h0;
      end else begin
         ck_sync_q <= ck_sync_d;
         cmp_sync_q <= cmp_sync_d;
      end
   end

   // one-cycle strobe on each rising edge of the conversion clock
   assign tick = ck_sync_q[1] & ~ck_sync_q[2];
   assign cmp_seen = cmp_sync_q[1];
   assign last_bit = (bit_q == 4'h0);
   assign next_bit = bit_q - 4'h1;

   // control: start, overhead count, trial pacing
   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      cnt_d = cnt_q;
      do_clear = 1'b0;
      do_msb = 1'b0;
      do_decide = 1'b0;
      case (st_q)
         SACS_IDLE: begin
            if (conversion_start_instr) begin
               do_clear = 1'b1;
               cnt_d = 8'(PREP_CLKS);
               st_d = SACS_PREP;
            end
         end
         SACS_PREP: begin
            // two machine cycles of overhead before the first trial
            if (cnt_q <= 8'h01) begin
               do_msb = 1'b1;
               bit_d = LAST_BIT;
               cnt_d = SETTLE_CLKS;
               st_d = SACS_TRY;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         SACS_TRY: begin
            // a tick too soon after a new code would judge a stale compare
            if (cnt_q != 8'h00) begin
               cnt_d = cnt_q - 8'h01;
            end else if (tick) begin
               do_decide = 1'b1;
               cnt_d = SETTLE_CLKS;
               if (last_bit) begin
                  st_d = SACS_DONE;
               end else begin
                  bit_d = next_bit;
               end
            end
         end
         SACS_DONE: begin
            st_d = SACS_IDLE;
         end
         default: begin
            st_d = SACS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= SACS_IDLE;
         bit_q <= 4'h0;
         cnt_q <= 8'h00;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         cnt_q <= cnt_d;
      end
   end

   // per bit: clear, seed the top bit, decide, seed the next lower bit
   for (genvar b = 0; b < RES_W; b++) begin : g_bit
      always_comb begin
         res_d[b] = res_q[b];
         if (do_clear) begin
            res_d[b] = RES_CLEAR[b];
         end else if (do_msb) begin
            res_d[b] = RES_MSB[b];
         end else if (do_decide) begin
            if (bit_q == 4'(b)) begin
               // comparator sampled at the end of the trial period
               res_d[b] = cmp_seen;
            end else if (!last_bit && (next_bit == 4'(b))) begin
               res_d[b] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         res_q <= RES_CLEAR;
      end else begin
         res_q <= res_d;
      end
   end

   // completion flag: set wins over a clear in the same cycle
   always_comb begin
      flag_d = flag_q;
      irq_d = 1'b0;
      if (done_flag_skip_instr | irq_taken) begin
         flag_d = 1'b0;
      end
      if (st_q == SACS_DONE) begin
         flag_d = 1'b1;
         irq_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   // outputs: partial values show during a conversion, so reads wait
   always_comb begin
      dac_code_d = res_d;
      result_d.hi = res_d[9:2];
      result_d.lo = res_d[1:0];
      busy_d = (st_d != SACS_IDLE);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_code <= RES_CLEAR;
         result <= '0;
         conversion_done_flag <= 1'b0;
         adc_irq_req <= 1'b0;
         busy <= 1'b0;
      end else begin
         dac_code <= dac_code_d;
         result <= result_d;
         conversion_done_flag <= flag_d;
         adc_irq_req <= irq_d;
         busy <= busy_d;
      end
   end
endmodule : sacs_sequencer

// ---- verilog/sacs_pkg.sv ----
// package for the conversion sequencer: widths, timing counts, carrier types
// assumes a single core clock of 50 MHz
package sacs_pkg;
   localparam int RES_W = 10;
   localparam logic [9:0] RES_CLEAR = 10'h000;
   localparam logic [9:0] RES_MSB = 10'h200;
   // start overhead of two machine cycles
   localparam int START_MCYC = 2;
   localparam int CORE_MHZ = 50;
   localparam int MCYC_NS = 1000;
   localparam int MCYC_CLKS = (MCYC_NS * CORE_MHZ + 999) / 1000;
   localparam int START_CLKS = START_MCYC * MCYC_CLKS;
   localparam logic [7:0] START_CLKS_W = 8'(START_CLKS);
   localparam logic [3:0] LAST_BIT = 4'h9;
   // cycles the ladder and the comparator sync need to follow a new code
   localparam logic [7:0] SETTLE_CLKS = 8'h02;

   typedef enum logic [3:0] {
      SACS_IDLE = 4'b0001,
      SACS_PREP = 4'b0010,
      SACS_TRY = 4'b0100,
      SACS_DONE = 4'b1000
   } sacs_state_t;

   // readout to the cpu: upper eight and lower two bits
   typedef struct packed {
      logic [7:0] hi;
      logic [1:0] lo;
   } sacs_result_t;
endpackage : sacs_pkg

// ---- testbench/sacs_sva.sv ----
// port checker for the sequencer, bound onto sacs_sequencer
`timescale 1ns/1ps
module sacs_sva import sacs_pkg::*; (
   input logic core_clk, rst_n, conversion_start_instr, done_flag_skip_instr, irq_taken,
   input logic [9:0] dac_code,
   input sacs_result_t result,
   input logic conversion_done_flag, adc_irq_req, busy
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_fin; adc_irq_req && !busy ##1 !adc_irq_req; endsequence
   property p_go; !busy && conversion_start_instr |=> busy && dac_code == RES_CLEAR; endproperty
   a_go: assert property (p_go) else $error("start");
   property p_msb; $rose(busy) |-> ##[1:8] dac_code == RES_MSB; endproperty
   a_msb: assert property (p_msb) else $error("top bit");
   property p_fin; $rose(conversion_done_flag) |-> s_fin; endproperty
   a_fin: assert property (p_fin) else $error("finish");
   property p_irq; adc_irq_req |-> $past(busy) && conversion_done_flag; endproperty
   a_irq: assert property (p_irq) else $error("irq");
   property p_clr; !busy && (done_flag_skip_instr || irq_taken) |=> !conversion_done_flag;
   endproperty
   a_clr: assert property (p_clr) else $error("clear");
   property p_nos; !busy && !conversion_done_flag |=> !conversion_done_flag; endproperty
   a_nos: assert property (p_nos) else $error("idle set");
   // result must stand while idle, since the cpu reads it then
   property p_hold; !busy && !conversion_start_instr |=> $stable(dac_code); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_one; busy && $changed(dac_code) |=> $stable(dac_code); endproperty
   a_one: assert property (p_one) else $error("trial rate");
   // both readout halves mirror the ladder code at every cycle
   property p_pair; {result.hi, result.lo} == dac_code; endproperty
   a_pair: assert property (p_pair) else $error("readout split");
endmodule : sacs_sva
bind sacs_sequencer sacs_sva u_sacs_sva (.*);

// ---- testbench/sacs_cmp.sv ----
// comparator and ladder model; analog_input_voltage is the input level in ladder steps
`timescale 1ns/1ps
module sacs_cmp (input logic [9:0] dac_code, analog_input_voltage, output logic cmp_ref_below);
   assign cmp_ref_below = dac_code < analog_input_voltage;
endmodule : sacs_cmp

// ---- testbench/testbench.sv ----
// bench: five conversions, a refused restart, both flag clears
`timescale 1ns/1ps
module testbench;
   logic core_clk = 0, rst_n = 0, conversion_start_instr = 0, done_flag_skip_instr = 0;
   logic irq_taken = 0, conversion_clock = 0, cmp_ref_below, conversion_done_flag;
   logic adc_irq_req, busy;
   logic [9:0] analog_input_voltage = 10'h000, dac_code, result;
   int n_fail = 0, n_checks = 0;
   sacs_sequencer #(.PREP_CLKS(2)) u_sacs_sequencer (.*);
   sacs_cmp u_sacs_cmp (.*);
   initial forever #10 core_clk = ~core_clk;
   // phase unrelated to the core clock on purpose
   initial #7 forever #60 conversion_clock = ~conversion_clock;
   task automatic chk(input logic [11:0] g, e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic step;
      @(posedge core_clk);
      #1;
   endtask : step
   task automatic convert(input logic [9:0] v, input logic skip, again);
      analog_input_voltage = v;
      conversion_start_instr = 1;
      step;
      conversion_start_instr = 0;
      chk({1'b0, busy, dac_code}, 12'h400);
      for (int i = 0; i < 400 && !conversion_done_flag; i++) begin
         conversion_start_instr = again && i == 20;
         if (again && i == 21) chk(12'(dac_code == 10'h000), 12'h000);
         step;
      end
      chk({conversion_done_flag, adc_irq_req, result}, {2'b11, v ? v - 10'h001 : 10'h000});
      step;
      chk({10'h000, conversion_done_flag, adc_irq_req}, 12'h002);
      done_flag_skip_instr = skip;
      irq_taken = !skip;
      step;
      done_flag_skip_instr = 0;
      irq_taken = 0;
      chk(12'(conversion_done_flag), 12'h000);
   endtask : convert
   task automatic report_and_stop;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   initial begin
      #100000;
      n_fail++;
      report_and_stop;
   end
   initial begin
      repeat (8) @(posedge core_clk);
      #1 rst_n = 1;
      convert(10'h000, 1, 0);
      convert(10'h3FF, 0, 1);
      convert(10'h200, 1, 0);
      convert(10'h155, 0, 0);
      convert(10'h001, 1, 0);
      report_and_stop;
   end
endmodule : testbench
